// ==== src/adc_diagnostic_sequencer.sv ====
// Diagnostic conversion sequencer with APB register access.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module adc_diagnostic_sequencer #(
  parameter int FIRST_FAST = adcds_pkg::CYC_FIRST_FAST,
  parameter int FIRST_NORM = adcds_pkg::CYC_FIRST_NORM,
  parameter int FIRST_ALT  = adcds_pkg::CYC_FIRST_ALT,
  parameter int FIRST_FILT = adcds_pkg::CYC_FIRST_FILT,
  parameter int NEXT_FAST  = adcds_pkg::CYC_NEXT_FAST,
  parameter int NEXT_NORM  = adcds_pkg::CYC_NEXT_NORM,
  parameter int NEXT_ALT   = adcds_pkg::CYC_NEXT_ALT,
  parameter int NEXT_FILT  = adcds_pkg::CYC_NEXT_FILT,
  parameter int MUX_REFERENCE_UP_STATE  = adcds_pkg::CYC_MUX_REFERENCE_UP_STATE,
  parameter int MUX_STBY   = adcds_pkg::CYC_MUX_STANDBY
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        modBit,
  input  wire logic        referenceUp,
  input  wire logic        muxDecodeFail,
  output logic             busy,
  output logic [5:0]       convChannel
);
  import adcds_pkg::*;
  localparam int CW = 24;
  initial begin
    if (FIRST_FILT >= (1 << CW) || MUX_STBY >= (1 << CW) || NEXT_FILT >= (1 << CW))
      $error("adc_diagnostic_sequencer: counts exceed counter width");
    if (FIRST_FAST < 2 || NEXT_FAST < 2 || MUX_REFERENCE_UP_STATE < 2)
      $error("adc_diagnostic_sequencer: counts too small");
  end
  typedef enum logic [1:0] { K_CELL, K_SUM, K_TEMP, K_SUPPLY } adcds_kind_e;
  typedef struct packed {
    adcds_state_e           state;
    logic [3:0]             cmd;
    logic [1:0]             mode;
    logic [1:0]             pattern;
    logic [CW-1:0]          timer;
    logic [5:0]             step;
    logic [5:0]             lastStep;
    logic                   firstConv;
    logic [11:0]            stackSum;
    logic [11:0]            dieTemp;
    logic [11:0]            supply;
    logic [11:0]            auxRef;
    logic [NUM_CELLS*12-1:0] cells;
    logic [NUM_AUX*16-1:0]  aux;
    logic [5:0]             cellIdx;
    logic [3:0]             auxIdx;
    logic                   muxFault;
    logic                   stA;
    logic                   stB;
    logic                   thermal_shutdown_flag;
    logic                   overTemp;
    logic                   underTemp;
    logic [NUM_OVUV-1:0]    overVolt;
    logic [NUM_OVUV-1:0]    underVolt;
    logic [31:0]            rdata;
    logic                   ready;
    logic                   err;
    logic                   modS1;
    logic                   modS2;
    logic                   refS1;
    logic                   refS2;
    logic                   failS1;
    logic                   failS2;
    logic                   muxSeen;
  } adcds_state_s;
  adcds_state_s st;
  adcds_state_s next_st;
  logic [11:0] filtWord;
  logic        filtStart;
  logic        filtDone;
  logic        testBit;
  logic        isSelfTest;
  logic        isSumStep;
  logic [11:0] testPat;
  // The test stream replaces the modulator, so filtering stays identical.
  assign isSelfTest = (st.cmd == CMD_CELLST) || (st.cmd == CMD_AUXST) || (st.cmd == CMD_STATUS_SELFTEST_CMD);
  assign testBit    = st.timer[0] ^ st.pattern[0];
  // Self-test results are the alternating patterns, with the fast-mode exception for every self-test but the cell self-test.
  always_comb begin
    testPat = (st.pattern == 2'b10) ? PAT_10 : PAT_01;
    if (st.mode == MODE_FAST && st.cmd != CMD_CELLST) begin
      testPat = (st.pattern == 2'b10) ? PAT_10_F : PAT_01_F;
    end
  end
  assign isSumStep = (st.cmd == CMD_CELLSUM) && (st.step == 6'(SUM_AFTER));
  assign filtStart = (st.state == ST_IDLE) || (st.state == ST_CALIB) || (st.timer == '0);
  assign filtDone  = (st.state == ST_CONV) && (st.timer == '0);
  adcds_filter #(
    .WIDTH (12)
  ) u_filter (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (filtStart),
    .bitIn   (isSelfTest ? testBit : st.modS2),
    .finish  (filtDone),
    .word    (filtWord)
  );
  function automatic logic [CW-1:0] firstCycles(input logic [1:0] m);
    case (m)
      MODE_FAST: firstCycles = CW'(FIRST_FAST);
      MODE_NORM: firstCycles = CW'(FIRST_NORM);
      MODE_ALT:  firstCycles = CW'(FIRST_ALT);
      default:   firstCycles = CW'(FIRST_FILT);
    endcase
  endfunction : firstCycles
  function automatic logic [CW-1:0] nextCycles(input logic [1:0] m);
    case (m)
      MODE_FAST: nextCycles = CW'(NEXT_FAST);
      MODE_NORM: nextCycles = CW'(NEXT_NORM);
      MODE_ALT:  nextCycles = CW'(NEXT_ALT);
      default:   nextCycles = CW'(NEXT_FILT);
    endcase
  endfunction : nextCycles
  always_comb begin
    logic [11:0] res;
    logic [5:0]  cellNo;
    logic [31:0] wd;
    res    = isSelfTest ? testPat : filtWord;
    cellNo = (st.cmd == CMD_CELLSUM && st.step > 6'(SUM_AFTER)) ? st.step - 6'd1 : st.step;
    wd     = pwdata;
    next_st = st;
    next_st.modS1  = modBit;
    next_st.modS2  = st.modS1;
    next_st.refS1  = referenceUp;
    next_st.refS2  = st.refS1;
    next_st.failS1 = muxDecodeFail;
    next_st.failS2 = st.failS1;
    next_st.ready  = 1'b0;
    next_st.err    = 1'b0;
    case (st.state)
      ST_IDLE: begin
      end
      ST_CONV: begin
        next_st.timer = st.timer - 1'b1;
        // Ending at zero lets each result land a full period after its start.
        if (st.timer == '0) begin
          // Results land in the group the command's conversion uses.
          case (st.cmd)
            CMD_INTERNAL, CMD_STATUS_SELFTEST_CMD: begin
              case (st.step)
                6'd0:    next_st.stackSum = res;
                6'd1:    next_st.dieTemp  = res;
                default: next_st.supply   = res;
              endcase
            end
            CMD_AUX: next_st.auxRef = res;
            CMD_AUXST: begin
              next_st.auxRef = res;
              for (int i = 0; i < NUM_AUX; i++) begin
                next_st.aux[i*16 +: 16] = {4'h0, res};
              end
            end
            default: begin
              if (isSumStep) begin
                next_st.stackSum = res;
              end else begin
                next_st.cells[cellNo*12 +: 12] = res;
              end
            end
          endcase
          next_st.firstConv = 1'b0;
          if (st.step == st.lastStep) begin
            next_st.state = ST_IDLE;
          end else begin
            next_st.step = st.step + 6'd1;
            next_st.timer = nextCycles(st.mode);
            // A switch between cell and sum conversions forces recalibration.
            if (st.cmd == CMD_CELLSUM &&
                (st.step == 6'(SUM_AFTER - 1) || st.step == 6'(SUM_AFTER))) begin
              next_st.state = ST_CALIB;
              next_st.timer = firstCycles(st.mode);
            end
          end
        end
      end
      ST_CALIB: begin
        // Calibration costs one first-conversion period before resuming.
        next_st.timer = st.timer - 1'b1;
        if (st.timer == '0) begin
          next_st.timer = nextCycles(st.mode);
          next_st.state = ST_CONV;
        end
      end
      ST_MUX: begin
        next_st.timer = st.timer - 1'b1;
        if (st.failS2) begin
          next_st.muxSeen = 1'b1;
        end
        if (st.timer == CW'(1)) begin
          next_st.muxFault = st.muxSeen || st.failS2;
          next_st.state    = ST_IDLE;
        end
      end
      default: next_st.state = ST_IDLE;
    endcase
    // APB access phase completes with one wait state.
    if (psel && penable && !st.ready) begin
      next_st.ready = 1'b1;
      next_st.rdata = '0;
      if (pwrite) begin
        case (paddr)
          OFF_CMD: begin
            if (st.state == ST_IDLE) begin
              next_st.cmd     = wd[CMD_LSB +: 4];
              next_st.mode    = wd[MODE_LSB +: 2];
              next_st.pattern = wd[PATTERN_LSB +: 2];
              next_st.step    = '0;
              next_st.timer   = firstCycles(wd[MODE_LSB +: 2]);
              next_st.firstConv = 1'b1;
              case (wd[CMD_LSB +: 4])
                CMD_INTERNAL, CMD_STATUS_SELFTEST_CMD: begin
                  next_st.state = ST_CONV;
                  next_st.lastStep = 6'd2;
                end
                CMD_CELLSUM: begin
                  next_st.state = ST_CONV;
                  next_st.lastStep = 6'(NUM_CELLS);
                end
                CMD_CELLST: begin
                  next_st.state = ST_CONV;
                  next_st.lastStep = 6'(NUM_CELLS - 1);
                end
                CMD_AUX, CMD_AUXST: begin
                  next_st.state = ST_CONV;
                  next_st.lastStep = 6'd0;
                end
                CMD_MUXCHK: begin
                  next_st.state   = ST_MUX;
                  next_st.muxSeen = 1'b0;
                  next_st.timer   = st.refS2 ? CW'(MUX_REFERENCE_UP_STATE) : CW'(MUX_STBY);
                end
                CMD_CLEAR_CELL_CMD: begin
                  next_st.cells = '1;
                end
                CMD_CLEAR_AUX_CMD: begin
                  next_st.aux    = '1;
                  next_st.auxRef = CLEAR_CODE;
                end
                CMD_CLEAR_STATUS_CMD: begin
                  next_st.muxFault  = 1'b1;
                  next_st.stA       = 1'b1;
                  next_st.stB       = 1'b1;
                  next_st.thermal_shutdown_flag      = 1'b1;
                  next_st.overVolt  = '1;
                  next_st.underVolt = '1;
                  next_st.stackSum  = CLEAR_CODE;
                  next_st.dieTemp   = CLEAR_CODE;
                  next_st.supply    = CLEAR_CODE;
                end
                default: next_st.err = 1'b1;
              endcase
            end else begin
              next_st.err = 1'b1;
            end
          end
          OFF_CELLIDX: next_st.cellIdx = wd[5:0];
          OFF_AUXIDX:  next_st.auxIdx  = wd[3:0];
          default: next_st.err = 1'b1;
        endcase
      end else begin
        case (paddr)
          OFF_CMD:    next_st.rdata = {24'h0, st.pattern, st.mode, st.cmd};
          OFF_STATUS: next_st.rdata = {28'h0, st.refS2, st.firstConv, 1'b0,
                                       st.state != ST_IDLE};
          OFF_FLAGS:  next_st.rdata = {st.underVolt, st.overVolt, 2'b00, st.underTemp,
                                       st.overTemp, st.thermal_shutdown_flag, st.stB, st.stA, st.muxFault};
          OFF_STACK:  next_st.rdata = {20'h0, st.stackSum};
          OFF_TEMP:   next_st.rdata = {20'h0, st.dieTemp};
          OFF_SUPPLY: next_st.rdata = {20'h0, st.supply};
          OFF_AUXREF: next_st.rdata = {20'h0, st.auxRef};
          OFF_CELLIDX: next_st.rdata = {26'h0, st.cellIdx};
          OFF_AUXIDX:  next_st.rdata = {28'h0, st.auxIdx};
          OFF_CELLDATA: begin
            if (st.cellIdx < 6'(NUM_CELLS)) begin
              next_st.rdata = {20'h0, st.cells[st.cellIdx*12 +: 12]};
            end
          end
          OFF_AUXDATA: begin
            if (st.auxIdx < 4'(NUM_AUX)) begin
              next_st.rdata = {16'h0, st.aux[st.auxIdx*16 +: 16]};
            end
          end
          default: next_st.err = 1'b1;
        endcase
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st           <= '0;
      st.state     <= ST_IDLE;
      st.stackSum  <= CLEAR_CODE;
      st.dieTemp   <= CLEAR_CODE;
      st.supply    <= CLEAR_CODE;
      st.auxRef    <= CLEAR_CODE;
      st.cells     <= '1;
      st.aux       <= '1;
      st.muxFault  <= 1'b1;
      st.stA       <= 1'b1;
      st.stB       <= 1'b1;
      st.thermal_shutdown_flag      <= 1'b1;
      st.overTemp  <= 1'b1;
      st.underTemp <= 1'b1;
      st.overVolt  <= '1;
      st.underVolt <= '1;
    end else begin
      st <= next_st;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy        <= 1'b0;
      convChannel <= '0;
    end else begin
      busy        <= next_st.state != ST_IDLE;
      convChannel <= next_st.step;
    end
  end
  assign prdata  = st.rdata;
  assign pready  = st.ready;
  assign pslverr = st.err;
endmodule : adc_diagnostic_sequencer

// ==== src/adcds_filter.sv ====
// Decimating counter filter turning a one-bit stream into a 12-bit word.
`timescale 1ns/1ps
module adcds_filter #(
  parameter int WIDTH = 12
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic             bitIn,
  input  wire logic             finish,
  output logic [WIDTH-1:0]      word
);
  import adcds_pkg::*;
  initial begin
    if (WIDTH < 2 || WIDTH > 16) $error("adcds_filter: WIDTH out of range");
  end
  typedef struct packed {
    logic [WIDTH-1:0] acc;
    logic [WIDTH-1:0] word;
  } adcds_filt_s;
  adcds_filt_s st;
  adcds_filt_s next_st;
  // Ones are counted over the window and the count saturates at full scale.
  always_comb begin
    next_st = st;
    if (start) begin
      next_st.acc = '0;
    end else if (bitIn && st.acc != {WIDTH{1'b1}}) begin
      next_st.acc = st.acc + 1'b1;
    end
    if (finish) begin
      next_st.word = st.acc;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign word = st.word;
endmodule : adcds_filter

// ==== src/adcds_pkg.sv ====
// Package of constants and types for the diagnostic sequencer.
package adcds_pkg;
  // Register offsets (byte addresses, one 32-bit word each).
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_STATUS   = 8'h04;
  localparam logic [7:0] OFF_FLAGS    = 8'h08;
  localparam logic [7:0] OFF_STACK    = 8'h0C;
  localparam logic [7:0] OFF_TEMP     = 8'h10;
  localparam logic [7:0] OFF_SUPPLY   = 8'h14;
  localparam logic [7:0] OFF_AUXREF   = 8'h18;
  localparam logic [7:0] OFF_CELLIDX  = 8'h1C;
  localparam logic [7:0] OFF_CELLDATA = 8'h20;
  localparam logic [7:0] OFF_AUXIDX   = 8'h24;
  localparam logic [7:0] OFF_AUXDATA  = 8'h28;
  // Command codes written to the command register.
  localparam logic [3:0] CMD_INTERNAL = 4'h1;
  localparam logic [3:0] CMD_CELLSUM  = 4'h2;
  localparam logic [3:0] CMD_AUX      = 4'h3;
  localparam logic [3:0] CMD_MUXCHK   = 4'h4;
  localparam logic [3:0] CMD_CELLST   = 4'h5;
  localparam logic [3:0] CMD_AUXST    = 4'h6;
  localparam logic [3:0] CMD_STATUS_SELFTEST_CMD   = 4'h7;
  localparam logic [3:0] CMD_CLEAR_CELL_CMD  = 4'h8;
  localparam logic [3:0] CMD_CLEAR_AUX_CMD   = 4'h9;
  localparam logic [3:0] CMD_CLEAR_STATUS_CMD  = 4'hA;
  // Command register field positions.
  localparam int CMD_LSB     = 0;
  localparam int MODE_LSB    = 4;
  localparam int PATTERN_LSB = 6;
  // Conversion mode codes.
  localparam logic [1:0] MODE_FAST = 2'h0;
  localparam logic [1:0] MODE_NORM = 2'h1;
  localparam logic [1:0] MODE_ALT  = 2'h2;
  localparam logic [1:0] MODE_FILT = 2'h3;
  // Flag register bit positions.
  localparam int FLAG_MUX   = 0;
  localparam int FLAG_STA   = 1;
  localparam int FLAG_STB   = 2;
  localparam int FLAG_THERMAL_SHUTDOWN_FLAG  = 3;
  localparam int FLAG_OT    = 4;
  localparam int FLAG_UT    = 5;
  localparam int FLAG_OVLSB = 8;
  localparam int FLAG_UVLSB = 20;
  localparam int NUM_OVUV   = 12;
  // Reset, clear and self-test result values.
  localparam logic [11:0] CLEAR_CODE = 12'hFFF;
  localparam logic [15:0] CLEAR_WORD = 16'hFFFF;
  localparam logic [11:0] PAT_01     = 12'h555;
  localparam logic [11:0] PAT_10     = 12'hAAA;
  localparam logic [11:0] PAT_01_F   = 12'h554;
  localparam logic [11:0] PAT_10_F   = 12'hAA8;
  // Times in nanoseconds, as printed in microseconds times 1000.
  localparam int CLK_NS        = 10;
  localparam int T_FIRST_FAST  = 112000;
  localparam int T_FIRST_NORM  = 208000;
  localparam int T_FIRST_ALT   = 336000;
  localparam int T_FIRST_FILT  = 1104000;
  localparam int T_NEXT_FAST   = 117500;
  localparam int T_NEXT_NORM   = 213500;
  localparam int T_NEXT_ALT    = 341500;
  localparam int T_NEXT_FILT   = 1109500;
  localparam int T_MUX_REFERENCE_UP_STATE   = 600000;
  localparam int T_MUX_STANDBY = 7600000;
  localparam int CYC_FIRST_FAST = T_FIRST_FAST / CLK_NS;
  localparam int CYC_FIRST_NORM = T_FIRST_NORM / CLK_NS;
  localparam int CYC_FIRST_ALT  = T_FIRST_ALT / CLK_NS;
  localparam int CYC_FIRST_FILT = T_FIRST_FILT / CLK_NS;
  localparam int CYC_NEXT_FAST  = T_NEXT_FAST / CLK_NS;
  localparam int CYC_NEXT_NORM  = T_NEXT_NORM / CLK_NS;
  localparam int CYC_NEXT_ALT   = T_NEXT_ALT / CLK_NS;
  localparam int CYC_NEXT_FILT  = T_NEXT_FILT / CLK_NS;
  localparam int CYC_MUX_REFERENCE_UP_STATE   = T_MUX_REFERENCE_UP_STATE / CLK_NS;
  localparam int CYC_MUX_STANDBY = T_MUX_STANDBY / CLK_NS;
  localparam int NUM_CELLS = 36;
  localparam int SUM_AFTER = 18;
  localparam int NUM_AUX   = 12;
  localparam int DECIM_LEN = 4096;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CONV, ST_CALIB, ST_MUX
  } adcds_state_e;
endpackage : adcds_pkg

// ==== tb/adc_diagnostic_sequencer_tb.sv ====
// Self-checking bench for the diagnostic sequencer.
`timescale 1ns/1ps
module adc_diagnostic_sequencer_tb;
  import adcds_pkg::*;
  typedef struct {logic [31:0] m; logic [31:0] v; logic e;} adcds_exp_s;
  localparam int FT[4] = '{20, 25, 30, 40};
  localparam int NT[4] = '{24, 30, 36, 44};
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, busy;
  logic        modBit, referenceUp, muxDecodeFail, refUpReq, failReq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  convChannel, maxCh;
  logic [15:0] seed;
  logic [11:0] v, w;
  adcds_exp_s  q[$], e;
  int          error_cnt = 0, checks = 0, cyc = 0, n, t[4];

  adc_diagnostic_sequencer #(
    .FIRST_FAST(FT[0]), .FIRST_NORM(FT[1]), .FIRST_ALT(FT[2]), .FIRST_FILT(FT[3]),
    .NEXT_FAST(NT[0]), .NEXT_NORM(NT[1]), .NEXT_ALT(NT[2]), .NEXT_FILT(NT[3]),
    .MUX_REFERENCE_UP_STATE(50), .MUX_STBY(200)
  ) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .modBit(modBit), .referenceUp(referenceUp),
    .muxDecodeFail(muxDecodeFail), .busy(busy), .convChannel(convChannel)
  );
  adcds_front_model front (
    .ref_clk(ref_clk), .rst_n(rst_n), .seed(seed), .refUpReq(refUpReq),
    .failReq(failReq), .modBit(modBit), .referenceUp(referenceUp),
    .muxDecodeFail(muxDecodeFail)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask : chk

  // The expectation is queued first; the monitor judges it when pready shows.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] x, input logic er);
    q.push_back('{m, x, er});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps the next call from re-driving psel in this step.
    @(posedge ref_clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0, m, x, 1'b0);
  endtask : rd

  task automatic wait_idle(output int k);
    k = 0;
    while (busy === 1'b1) begin
      @(posedge ref_clk);
      k++;
    end
  endtask : wait_idle

  task automatic run(input logic [7:0] c, output int k);
    apb(1'b1, OFF_CMD, {24'h0, c}, 32'h0, 32'h0, 1'b0);
    wait_idle(k);
  endtask : run

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  always @(negedge ref_clk) begin
    if (pready === 1'b1) begin
      e = q.pop_front();
      chk("prdata", prdata & e.m, e.v);
      chk("pslverr", {31'h0, pslverr}, {31'h0, e.e});
    end
    if (busy === 1'b1 && convChannel > maxCh) maxCh = convChannel;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, refUpReq, failReq} = '0;
    rst_n = 1'b0;
    maxCh = '0;
    void'($urandom(32'h2EAC));
    seed = 16'($urandom);
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(OFF_STACK, 32'hFFF, 32'hFFF);
    rd(OFF_FLAGS, 32'hFFFFFF3F, 32'hFFFFFF3F);
    apb(1'b0, 8'h2C, 32'h0, 32'hFFFFFFFF, 32'h0, 1'b1);
    apb(1'b1, OFF_CMD, 32'h0000000F, 32'h0, 32'h0, 1'b1);
    $display("reset and map test done");
    refUpReq <= 1'b1;
    repeat (3) @(posedge ref_clk);
    run({4'h0, CMD_MUXCHK}, n);
    chk("muxShort", n >= 48 && n <= 60, 1);
    rd(OFF_FLAGS, 32'h1, 32'h0);
    refUpReq <= 1'b0;
    failReq <= 1'b1;
    repeat (3) @(posedge ref_clk);
    run({4'h0, CMD_MUXCHK}, n);
    chk("muxLong", n >= 198 && n <= 210, 1);
    rd(OFF_FLAGS, 32'h1, 32'h1);
    failReq <= 1'b0;
    refUpReq <= 1'b1;
    repeat (3) @(posedge ref_clk);
    run({4'h0, CMD_MUXCHK}, n);
    run({4'h0, CMD_CLEAR_STATUS_CMD}, n);
    rd(OFF_FLAGS, 32'hFFFFFF3F, 32'hFFFFFF3F);
    $display("mux check test done");
    for (int m = 0; m < 4; m++) begin
      run({2'b00, 2'(m), CMD_INTERNAL}, t[m]);
      chk("intTime", t[m] >= FT[m] + 2 * NT[m] - 2 && t[m] <= FT[m] + 2 * NT[m] + 8, 1);
      for (int p = 1; p < 3; p++) begin
        w = (p == 1) ? PAT_01 : PAT_10;
        v = (m == 0) ? ((p == 1) ? PAT_01_F : PAT_10_F) : w;
        run({2'(p), 2'(m), CMD_STATUS_SELFTEST_CMD}, n);
        chk("stTime", n, t[m]);
        rd(OFF_TEMP, 32'hFFF, {20'h0, v});
        run({2'(p), 2'(m), CMD_AUXST}, n);
        rd(OFF_AUXREF, 32'hFFF, {20'h0, v});
        run({2'(p), 2'(m), CMD_CELLST}, n);
        apb(1'b1, OFF_CELLIDX, 32'($urandom_range(35)), 32'h0, 32'h0, 1'b0);
        rd(OFF_CELLDATA, 32'hFFF, {20'h0, w});
      end
    end
    $display("self-test and timing test done");
    apb(1'b1, OFF_CMD, {24'h0, 2'b00, MODE_FILT, CMD_INTERNAL}, 32'h0, 32'h0, 1'b0);
    apb(1'b1, OFF_CMD, {28'h0, CMD_CLEAR_CELL_CMD}, 32'h0, 32'h0, 1'b1);
    rd(OFF_STATUS, 32'h1, 32'h1);
    wait_idle(n);
    rd(OFF_STATUS, 32'h1, 32'h0);
    rd(OFF_CELLDATA, 32'hFFF, {20'h0, w});
    maxCh = '0;
    run({4'h0, CMD_CELLSUM}, n);
    chk("sumSteps", {26'h0, maxCh}, 36);
    chk("calibTime", n >= 3 * FT[0] + 36 * NT[0] - 2, 1);
    $display("refusal and cells-plus-sum test done");
    run({4'h0, CMD_CLEAR_AUX_CMD}, n);
    rd(OFF_AUXREF, 32'hFFF, 32'hFFF);
    apb(1'b1, OFF_AUXIDX, 32'h3, 32'h0, 32'h0, 1'b0);
    rd(OFF_AUXDATA, 32'hFFFF, 32'hFFFF);
    run({4'h0, CMD_AUX}, n);
    rd(OFF_AUXREF, 32'hF000, 32'h0);
    run({4'h0, CMD_CLEAR_CELL_CMD}, n);
    rd(OFF_CELLDATA, 32'hFFF, 32'hFFF);
    run({4'h0, CMD_CLEAR_STATUS_CMD}, n);
    rd(OFF_STACK, 32'hFFF, 32'hFFF);
    rd(OFF_SUPPLY, 32'hFFF, 32'hFFF);
    $display("clear test done");
    repeat (2) @(posedge ref_clk);
    complete_run();
  end
endmodule : adc_diagnostic_sequencer_tb

// ==== tb/adcds_front_model.sv ====
// Front-end stand-in: modulator stream, reference state and decoder fault.
`timescale 1ns/1ps
module adcds_front_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] seed,
  input  wire logic        refUpReq,
  input  wire logic        failReq,
  output logic             modBit,
  output logic             referenceUp,
  output logic             muxDecodeFail
);
  logic [15:0] lfsr;
  // A shift register keeps the stream changing without a fixed duty cycle.
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) lfsr <= seed | 16'h0001;
    else lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? 16'hB400 : 16'h0000);
  end
  assign modBit        = lfsr[0];
  assign referenceUp   = refUpReq;
  assign muxDecodeFail = failReq;
endmodule : adcds_front_model

// ==== tb/adcds_seq_sva.sv ====
// Checker for the sequencer's bus handshake, refusals and busy behaviour.
`timescale 1ns/1ps
module adcds_sva_chk
  import adcds_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic        cmdWr;
  logic [12:0] busyRun;
  assign cmdWr = pready && pwrite && paddr == OFF_CMD && !pslverr;
  // A stuck busy flag would hang every host poll, so its run length is bounded.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) busyRun <= '0;
    else busyRun <= busy ? busyRun + 13'h1 : '0;
  end
  property p_rdyAfterAccess; psel && penable && !pready |=> pready; endproperty
  a_rdyAfterAccess: assert property (p_rdyAfterAccess) else $error("pready late");
  property p_rdyPulse; pready |=> !pready; endproperty
  a_rdyPulse: assert property (p_rdyPulse) else $error("pready too long");
  property p_errWithRdy; pslverr |-> pready; endproperty
  a_errWithRdy: assert property (p_errWithRdy) else $error("pslverr alone");
  property p_rdyCause; pready |-> $past(psel && penable); endproperty
  a_rdyCause: assert property (p_rdyCause) else $error("pready uncalled");
  property p_convBusy;
    cmdWr && pwdata[3:0] >= CMD_INTERNAL && pwdata[3:0] <= CMD_STATUS_SELFTEST_CMD |-> ##[1:2] busy;
  endproperty
  a_convBusy: assert property (p_convBusy) else $error("no busy");
  property p_clearQuiet;
    cmdWr && pwdata[3:0] >= CMD_CLEAR_CELL_CMD && pwdata[3:0] <= CMD_CLEAR_STATUS_CMD |=> !busy [*2];
  endproperty
  a_clearQuiet: assert property (p_clearQuiet) else $error("clear busy");
  property p_busyRefuse;
    pready && pwrite && paddr == OFF_CMD && busy && $past(busy) |-> pslverr;
  endproperty
  a_busyRefuse: assert property (p_busyRefuse) else $error("busy cmd taken");
  property p_unmapped; pready && paddr > OFF_AUXDATA |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped ok");
  property p_busyBound; busyRun < 13'd4000; endproperty
  a_busyBound: assert property (p_busyBound) else $error("busy stuck");
  property p_statusBusy;
    pready && !pwrite && paddr == OFF_STATUS && $past(busy) == busy
      && $past(busy, 2) == busy |-> prdata[0] == busy;
  endproperty
  a_statusBusy: assert property (p_statusBusy) else $error("status busy");
  c_cmd: cover property (cmdWr);
  c_refuse: cover property (pready && pslverr && paddr == OFF_CMD);
  c_done: cover property ($fell(busy));
endmodule : adcds_sva_chk

bind adc_diagnostic_sequencer adcds_sva_chk u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .busy(busy)
);
